//--- shared/homing_params.svh
// constants for the switch-and-index homing sequencer
// assumes a single 100 MHz clock and the homing_pkg types
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH

// homing method codes handled here
`define HS_METHOD_7 4'h7
`define HS_METHOD_8 4'h8
`define HS_METHOD_9 4'h9
`define HS_METHOD_10 4'hA
`define HS_METHOD_11 4'hB

// clock and time base
`define HS_CLK_PERIOD_NS 10
`define HS_MS_NS 1000000

// pin synchroniser bit positions
`define HS_PIN_W 5
`define HS_PIN_TRIG 0
`define HS_PIN_HOME 1
`define HS_PIN_FLIM 2
`define HS_PIN_RLIM 3
`define HS_PIN_Z 4

// widths
`define HS_SPEED_W 15
`define HS_POS_W 32
`define HS_MS_CNT_W 17
`define HS_SETTLE_W 16
`define HS_WINDOW_W 16

// reset values
`define HS_SPEED_ZERO 15'h0000
`define HS_POS_ZERO 32'h00000000
`define HS_MS_CNT_ZERO 17'h00000
`define HS_MS_CNT_ONE 17'h00001
`define HS_SETTLE_ZERO 16'h0000
`define HS_SETTLE_ONE 16'h0001

`endif

//--- shared/homing_pkg.sv
// types for the switch-and-index homing sequencer
// assumes homing_params.svh for widths
`include "homing_params.svh"

package homing_pkg;

  // command to the motion loop
  typedef struct packed {
    logic run;
    logic fwd;
    logic [`HS_SPEED_W-1:0] speed;
  } motion_cmd_t;

  // sequencer phases
  typedef enum logic [8:0] {
    ST_IDLE     = 9'b000000001,
    ST_SEEK     = 9'b000000010,
    ST_LIMREV   = 9'b000000100,
    ST_PASS     = 9'b000001000,
    ST_APPROACH = 9'b000010000,
    ST_ZWAIT    = 9'b000100000,
    ST_SETTLE   = 9'b001000000,
    ST_DONE     = 9'b010000000,
    ST_FAULT    = 9'b100000000
  } home_state_t;

endpackage

//--- rtl/homing_sequencer_switch_z.sv
// homing sequencer for methods 7 to 11: home switch, one limit switch, index pulse
// assumes switch and index pins are asynchronous; parameters and position come from clk logic
//
// What this block does
// - start on trigger; home level picks start
// - 7-10 use forward limit, 11 reverse
// - m7 low: fast forward, reverse slow, Z low
// - m7 high: reverse slow, Z while low
// - m7 limit: reverse fast, slow at home
// - m8 low: fast forward, slow at home
// - m8 high: reverse, forward on low, Z
// - m8 limit: fast through home, slow back
// - m9 low: slow at home, reverse on low
// - m9 high: forward slow, reverse on low
// - m9 limit: reverse, slow at home, Z
// - m10 low: fast then slow, Z low
// - m10 high: forward slow, Z while low
// - m10 limit: reverse, reverse again at home
// - m11 low: reverse fast, forward slow, Z low
// - m11 high: forward slow, Z while low
// - m11 limit: reverse limit flips, slow at home
// - first speed fast, second slow, 0 to 32767
// - done after window, zero speed, settle time
`timescale 1ns/1ps
`include "homing_params.svh"

module homing_sequencer_switch_z #(
  parameter int unsigned MS_CYCLES = `HS_MS_NS / `HS_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic homing_trigger_input,
  input wire logic home_switch_input,
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  input wire logic index_pulse_input,
  input wire logic [3:0] homing_method,
  input wire logic [`HS_SPEED_W-1:0] fast_homing_speed,
  input wire logic [`HS_SPEED_W-1:0] slow_homing_speed,
  input wire logic [`HS_WINDOW_W-1:0] zero_window_size,
  input wire logic [`HS_SETTLE_W-1:0] done_settle_time,
  input wire logic [`HS_POS_W-1:0] encoder_position,
  input wire logic speed_ref_zero,
  output homing_pkg::motion_cmd_t motion_cmd,
  output logic [`HS_POS_W-1:0] zero_position,
  output logic zero_found,
  output logic homing_busy,
  output logic homing_fault,
  output logic homing_done_output
);

  // ***************************************************
  // pin synchronisers and edge detect
  // ***************************************************
  logic [`HS_PIN_W-1:0] pins;
  logic [`HS_PIN_W-1:0] meta_reg;
  logic [`HS_PIN_W-1:0] sync_reg;
  logic [`HS_PIN_W-1:0] prev_reg;

  assign pins = {index_pulse_input, reverse_limit_input, forward_limit_input,
                 home_switch_input, homing_trigger_input};

  genvar gi;
  generate
    for (gi = 0; gi < `HS_PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
          prev_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= pins[gi];
          sync_reg[gi] <= meta_reg[gi];
          prev_reg[gi] <= sync_reg[gi];
        end
      end
    end
  endgenerate

  logic trig_rise;
  logic home_s;
  logic home_rise;
  logic home_fall;
  logic z_rise;
  logic limit_s;

  assign trig_rise = sync_reg[`HS_PIN_TRIG] & ~prev_reg[`HS_PIN_TRIG];
  assign home_s = sync_reg[`HS_PIN_HOME];
  assign home_rise = home_s & ~prev_reg[`HS_PIN_HOME];
  assign home_fall = ~home_s & prev_reg[`HS_PIN_HOME];
  assign z_rise = sync_reg[`HS_PIN_Z] & ~prev_reg[`HS_PIN_Z];

  // ***************************************************
  // sequencer
  // ***************************************************
  homing_pkg::home_state_t state_reg;
  homing_pkg::motion_cmd_t cmd_reg;
  logic [3:0] method_reg;
  logic zq_low_reg;
  logic [`HS_POS_W-1:0] zero_pos_reg;
  logic zero_found_reg;
  logic method_ok;
  logic can_start;
  logic z_take;
  logic settle_met;
  logic in_window;

  assign method_ok = (homing_method >= `HS_METHOD_7) && (homing_method <= `HS_METHOD_11);
  assign can_start = (state_reg == homing_pkg::ST_IDLE) || (state_reg == homing_pkg::ST_DONE) ||
                     (state_reg == homing_pkg::ST_FAULT);
  // method 11 watches the reverse limit, the others the forward one
  assign limit_s = (method_reg == `HS_METHOD_11) ? sync_reg[`HS_PIN_RLIM]
                                                 : sync_reg[`HS_PIN_FLIM];
  // index qualified by home low where the method asks for it
  assign z_take = z_rise && (!zq_low_reg || !home_s);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= homing_pkg::ST_IDLE;
      cmd_reg <= '{run: 1'b0, fwd: 1'b1, speed: `HS_SPEED_ZERO};
      method_reg <= `HS_METHOD_7;
      zq_low_reg <= 1'b1;
    end else if (trig_rise && can_start) begin
      method_reg <= homing_method;
      zq_low_reg <= 1'b1;
      if (!method_ok) begin
        state_reg <= homing_pkg::ST_FAULT;
        cmd_reg.run <= 1'b0;
      end else if (!home_s) begin
        state_reg <= homing_pkg::ST_SEEK;
        cmd_reg <= '{run: 1'b1, fwd: (homing_method != `HS_METHOD_11),
                     speed: fast_homing_speed};
      end else if (homing_method == `HS_METHOD_7) begin
        state_reg <= homing_pkg::ST_ZWAIT;
        cmd_reg <= '{run: 1'b1, fwd: 1'b0, speed: slow_homing_speed};
      end else if (homing_method == `HS_METHOD_8) begin
        state_reg <= homing_pkg::ST_PASS;
        cmd_reg <= '{run: 1'b1, fwd: 1'b0, speed: slow_homing_speed};
      end else if (homing_method == `HS_METHOD_9) begin
        state_reg <= homing_pkg::ST_PASS;
        cmd_reg <= '{run: 1'b1, fwd: 1'b1, speed: slow_homing_speed};
      end else begin
        state_reg <= homing_pkg::ST_ZWAIT;
        cmd_reg <= '{run: 1'b1, fwd: 1'b1, speed: slow_homing_speed};
      end
    end else begin
      unique case (state_reg)
        homing_pkg::ST_SEEK: begin
          if (limit_s && !home_s) begin
            state_reg <= homing_pkg::ST_LIMREV;
            cmd_reg.fwd <= !cmd_reg.fwd;
          end else if (home_rise) begin
            cmd_reg.speed <= slow_homing_speed;
            if (method_reg == `HS_METHOD_7) begin
              state_reg <= homing_pkg::ST_ZWAIT;
              cmd_reg.fwd <= 1'b0;
            end else if (method_reg == `HS_METHOD_8) begin
              state_reg <= homing_pkg::ST_ZWAIT;
              zq_low_reg <= 1'b0;
            end else if (method_reg == `HS_METHOD_9) begin
              state_reg <= homing_pkg::ST_PASS;
            end else if (method_reg == `HS_METHOD_10) begin
              state_reg <= homing_pkg::ST_ZWAIT;
            end else begin
              state_reg <= homing_pkg::ST_ZWAIT;
              cmd_reg.fwd <= 1'b1;
            end
          end
        end
        homing_pkg::ST_LIMREV: begin
          if (home_rise) begin
            if (method_reg == `HS_METHOD_8) begin
              state_reg <= homing_pkg::ST_PASS;
            end else begin
              state_reg <= homing_pkg::ST_ZWAIT;
              cmd_reg.speed <= slow_homing_speed;
              if (method_reg == `HS_METHOD_9) begin
                zq_low_reg <= 1'b0;
              end
              if (method_reg == `HS_METHOD_10) begin
                cmd_reg.fwd <= !cmd_reg.fwd;
              end
            end
          end
        end
        homing_pkg::ST_PASS: begin
          if (home_fall) begin
            state_reg <= homing_pkg::ST_APPROACH;
            cmd_reg.fwd <= !cmd_reg.fwd;
            cmd_reg.speed <= slow_homing_speed;
          end
        end
        homing_pkg::ST_APPROACH: begin
          if (home_rise) begin
            state_reg <= homing_pkg::ST_ZWAIT;
            zq_low_reg <= 1'b0;
          end
        end
        homing_pkg::ST_ZWAIT: begin
          if (z_take) begin
            state_reg <= homing_pkg::ST_SETTLE;
            cmd_reg.run <= 1'b0;
          end
        end
        homing_pkg::ST_SETTLE: begin
          if (settle_met) begin
            state_reg <= homing_pkg::ST_DONE;
          end
        end
        homing_pkg::ST_DONE: begin
          if (!in_window || !speed_ref_zero) begin
            state_reg <= homing_pkg::ST_SETTLE;
          end
        end
        homing_pkg::ST_IDLE, homing_pkg::ST_FAULT: begin
          cmd_reg.run <= 1'b0;
        end
      endcase
    end
  end

  // ***************************************************
  // zero point capture
  // ***************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_pos_reg <= `HS_POS_ZERO;
      zero_found_reg <= 1'b0;
    end else begin
      zero_found_reg <= (state_reg == homing_pkg::ST_ZWAIT) && z_take;
      if ((state_reg == homing_pkg::ST_ZWAIT) && z_take) begin
        zero_pos_reg <= encoder_position;
      end
    end
  end

  // ***************************************************
  // completion: window, zero speed, settle time
  // ***************************************************
  logic [`HS_POS_W-1:0] pos_diff;
  logic [`HS_POS_W-1:0] pos_abs;
  logic hold_ok;
  logic [`HS_MS_CNT_W-1:0] ms_cnt_reg;
  logic ms_tick;
  logic [`HS_SETTLE_W-1:0] settle_cnt_reg;

  assign pos_diff = encoder_position - zero_pos_reg;
  assign pos_abs = pos_diff[`HS_POS_W-1] ? (~pos_diff + `HS_POS_W'(1)) : pos_diff;
  assign in_window = pos_abs <= {{(`HS_POS_W-`HS_WINDOW_W){1'b0}}, zero_window_size};
  assign hold_ok = in_window && speed_ref_zero &&
                   ((state_reg == homing_pkg::ST_SETTLE) || (state_reg == homing_pkg::ST_DONE));
  assign ms_tick = (ms_cnt_reg == `HS_MS_CNT_W'(MS_CYCLES - 1));
  assign settle_met = hold_ok && (settle_cnt_reg >= done_settle_time);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_reg <= `HS_MS_CNT_ZERO;
    end else if (!hold_ok || ms_tick) begin
      ms_cnt_reg <= `HS_MS_CNT_ZERO;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + `HS_MS_CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt_reg <= `HS_SETTLE_ZERO;
    end else if (!hold_ok) begin
      settle_cnt_reg <= `HS_SETTLE_ZERO;
    end else if (ms_tick && (settle_cnt_reg < done_settle_time)) begin
      settle_cnt_reg <= settle_cnt_reg + `HS_SETTLE_ONE;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  logic done_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= settle_met && !(trig_rise && can_start);
    end
  end

  assign motion_cmd = cmd_reg;
  assign zero_position = zero_pos_reg;
  assign zero_found = zero_found_reg;
  assign homing_busy = cmd_reg.run;
  assign homing_fault = (state_reg == homing_pkg::ST_FAULT);
  assign homing_done_output = done_reg;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_start_on_trigger: assert property (
    (state_reg == homing_pkg::ST_IDLE) && !trig_rise |=> state_reg == homing_pkg::ST_IDLE)
    else $error("sequencer left idle without trigger");
  a_start_speed_level: assert property (
    trig_rise && can_start && method_ok |=> cmd_reg.run &&
    (cmd_reg.speed == ($past(home_s) ? $past(slow_homing_speed) : $past(fast_homing_speed))))
    else $error("start speed does not follow home level");
  a_bad_method_fault: assert property (
    trig_rise && can_start && !method_ok |=> homing_fault && !motion_cmd.run)
    else $error("unsupported method not refused");
  a_seek_direction: assert property (
    state_reg == homing_pkg::ST_SEEK |-> cmd_reg.fwd == (method_reg != `HS_METHOD_11) &&
    cmd_reg.speed != slow_homing_speed || fast_homing_speed == slow_homing_speed)
    else $error("seek direction or speed wrong");
  a_limit_reverse: assert property (
    (state_reg == homing_pkg::ST_SEEK) && limit_s && !home_s && !trig_rise |=>
    (state_reg == homing_pkg::ST_LIMREV) && (cmd_reg.fwd != $past(cmd_reg.fwd)))
    else $error("limit did not reverse the axis");
  a_pass_reverse_slow: assert property (
    (state_reg == homing_pkg::ST_PASS) && home_fall |=>
    (state_reg == homing_pkg::ST_APPROACH) && (cmd_reg.fwd != $past(cmd_reg.fwd)) &&
    (cmd_reg.speed == $past(slow_homing_speed)))
    else $error("home fall did not reverse at slow speed");
  a_zwait_slow: assert property (
    state_reg == homing_pkg::ST_ZWAIT |-> cmd_reg.run && cmd_reg.speed == slow_homing_speed)
    else $error("index search not at slow speed");
  a_zero_latch: assert property (
    (state_reg == homing_pkg::ST_ZWAIT) && z_take |=>
    zero_found && !motion_cmd.run && (zero_position == $past(encoder_position)))
    else $error("index did not latch zero and stop");
  a_z_qualified: assert property (
    (state_reg == homing_pkg::ST_ZWAIT) && zq_low_reg && home_s |=> state_reg != homing_pkg::ST_SETTLE)
    else $error("index taken with home switch high");
  a_done_needs_hold: assert property (
    homing_done_output |-> $past(in_window) && $past(speed_ref_zero) &&
    ($past(settle_cnt_reg) >= $past(done_settle_time)))
    else $error("done raised without settled zero");

  c_limit_case: cover property ((state_reg == homing_pkg::ST_SEEK) ##1 (state_reg == homing_pkg::ST_LIMREV));
  c_approach: cover property ((state_reg == homing_pkg::ST_PASS) ##1 (state_reg == homing_pkg::ST_APPROACH));
  c_zero_found: cover property (zero_found && (method_reg == `HS_METHOD_11));
  c_done: cover property ($rose(homing_done_output));

endmodule

//--- verif/axis_model.sv
// axis model: home switch, limit switches, encoder Z index and position
// assumes the homing sequencer motion command on the same clock
`timescale 1ns/1ps
`include "homing_params.svh"

module axis_model #(
  parameter int HOME_LO = 64,
  parameter int HOME_HI = 127,
  parameter int FWD_LIM = 192,
  parameter int REV_LIM = -64
) (
  input wire logic clk,
  input wire logic arst_n,
  input homing_pkg::motion_cmd_t motion_cmd,
  input wire logic load,
  input wire logic [`HS_POS_W-1:0] load_pos,
  output logic home_switch_input,
  output logic forward_limit_input,
  output logic reverse_limit_input,
  output logic index_pulse_input,
  output logic [`HS_POS_W-1:0] encoder_position
);
  int pos_reg;
  logic half_reg;
  int z_phase;

  // ****************************************
  // position: one count every two clocks
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_reg <= 0;
      half_reg <= 1'b0;
    end else if (load) begin
      pos_reg <= int'(signed'(load_pos));
      half_reg <= 1'b0;
    end else if (motion_cmd.run) begin
      half_reg <= ~half_reg;
      if (half_reg) begin
        pos_reg <= motion_cmd.fwd ? pos_reg + 1 : pos_reg - 1;
      end
    end
  end

  // ****************************************
  // switches and index band (8 clocks high)
  // ****************************************
  assign z_phase = ((pos_reg % 16) + 16) % 16;
  assign index_pulse_input = (z_phase >= 6) && (z_phase <= 9);
  assign home_switch_input = (pos_reg >= HOME_LO) && (pos_reg <= HOME_HI);
  assign forward_limit_input = pos_reg >= FWD_LIM;
  assign reverse_limit_input = pos_reg <= REV_LIM;
  assign encoder_position = pos_reg;
endmodule

//--- verif/tb.sv
// testbench for the homing sequencer, methods 7 to 11, against the axis model
// assumes homing_pkg, homing_params.svh and axis_model
`timescale 1ns/1ps
`include "homing_params.svh"

module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic trig = 1'b0;
  logic [3:0] meth = 4'h7;
  logic [`HS_SPEED_W-1:0] fast_spd = 15'h0100;
  logic [`HS_SPEED_W-1:0] slow_spd = 15'h7FFF;
  logic [`HS_WINDOW_W-1:0] win = 16'hFFFF;
  logic [`HS_SETTLE_W-1:0] settle = 16'h0002;
  logic spd_zero = 1'b1;
  logic load = 1'b0;
  logic [`HS_POS_W-1:0] load_pos = 32'h00000000;
  logic home, flim, rlim, zpin, zfound, busy, fault, done;
  logic [`HS_POS_W-1:0] enc, zpos;
  homing_pkg::motion_cmd_t cmd;
  int n_mismatch = 0;
  int checks_done = 0;

  always #5 clk = ~clk;

  homing_sequencer_switch_z #(.MS_CYCLES(10)) homing_sequencer_switch_z_inst (
    .clk(clk), .arst_n(arst_n), .homing_trigger_input(trig), .home_switch_input(home),
    .forward_limit_input(flim), .reverse_limit_input(rlim), .index_pulse_input(zpin),
    .homing_method(meth), .fast_homing_speed(fast_spd), .slow_homing_speed(slow_spd),
    .zero_window_size(win), .done_settle_time(settle), .encoder_position(enc),
    .speed_ref_zero(spd_zero), .motion_cmd(cmd), .zero_position(zpos), .zero_found(zfound),
    .homing_busy(busy), .homing_fault(fault), .homing_done_output(done));

  axis_model axis_model_inst (
    .clk(clk), .arst_n(arst_n), .motion_cmd(cmd), .load(load), .load_pos(load_pos),
    .home_switch_input(home), .forward_limit_input(flim), .reverse_limit_input(rlim),
    .index_pulse_input(zpin), .encoder_position(enc));

  // ****************************************
  // reporting
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic ok);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // one homing run: start, end command, zero, done
  // ****************************************
  task automatic home_run(input logic [3:0] m, input int start, input logic f0, input logic s0,
                          input logic f1, input int z);
    int n;
    int diff;
    homing_pkg::motion_cmd_t exp0;
    homing_pkg::motion_cmd_t last;
    exp0 = {1'b1, f0, s0 ? slow_spd : fast_spd};
    last = '0;
    n = 0;
    @(negedge clk);
    meth = m;
    load = 1'b1;
    load_pos = start;
    @(negedge clk);
    load = 1'b0;
    trig = 1'b1;
    repeat (3) @(negedge clk);
    trig = 1'b0;
    while (cmd.run !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(cmd, exp0, cmd === exp0);
    check(busy, 1, busy === 1'b1);
    if (cmd.run !== 1'b1) tally_and_finish();
    n = 0;
    while (zfound !== 1'b1 && n < 3000) begin
      if (cmd.run === 1'b1) last = cmd;
      @(negedge clk);
      n++;
    end
    check(zfound, 1, zfound === 1'b1);
    if (zfound !== 1'b1) tally_and_finish();
    check(last, {1'b1, f1, slow_spd}, last === {1'b1, f1, slow_spd});
    diff = int'(signed'(zpos)) - z;
    check(zpos, z, diff >= -3 && diff <= 3);
    @(negedge clk);
    check(cmd.run, 0, cmd.run === 1'b0);
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(done, 1, done === 1'b1);
    if (done !== 1'b1) tally_and_finish();
  endtask

  // ****************************************
  // scenarios, one per method
  // ****************************************
  task automatic method_7();
    home_run(4'h7, 0, 1'b1, 1'b0, 1'b0, 57);
    home_run(4'h7, 100, 1'b0, 1'b1, 1'b0, 57);
    home_run(4'h7, 140, 1'b1, 1'b0, 1'b0, 57);
  endtask

  task automatic method_8();
    home_run(4'h8, 0, 1'b1, 1'b0, 1'b1, 70);
    home_run(4'h8, 100, 1'b0, 1'b1, 1'b1, 70);
    home_run(4'h8, 140, 1'b1, 1'b0, 1'b1, 70);
  endtask

  task automatic method_9();
    home_run(4'h9, 0, 1'b1, 1'b0, 1'b0, 121);
    home_run(4'h9, 100, 1'b1, 1'b1, 1'b0, 121);
    home_run(4'h9, 140, 1'b1, 1'b0, 1'b0, 121);
  endtask

  task automatic method_10();
    home_run(4'hA, 0, 1'b1, 1'b0, 1'b1, 134);
    home_run(4'hA, 100, 1'b1, 1'b1, 1'b1, 134);
    home_run(4'hA, 140, 1'b1, 1'b0, 1'b1, 134);
  endtask

  task automatic method_11();
    home_run(4'hB, 200, 1'b0, 1'b0, 1'b1, 134);
    home_run(4'hB, 100, 1'b1, 1'b1, 1'b1, 134);
    home_run(4'hB, 30, 1'b0, 1'b0, 1'b1, 134);
  endtask

  // unsupported code: no motion, fault flag
  task automatic bad_method();
    @(negedge clk);
    meth = 4'h3;
    trig = 1'b1;
    repeat (3) @(negedge clk);
    trig = 1'b0;
    repeat (4) @(negedge clk);
    check(fault, 1, fault === 1'b1);
    check(cmd.run, 0, cmd.run === 1'b0);
  endtask

  // done follows window, zero speed reference and settle time
  task automatic done_window();
    int zp;
    int n;
    zp = int'(signed'(zpos));
    n = 0;
    @(negedge clk);
    win = 16'h0004;
    load = 1'b1;
    load_pos = zp + 5;
    @(negedge clk);
    load = 1'b0;
    repeat (3) @(negedge clk);
    check(done, 0, done === 1'b0);
    load = 1'b1;
    load_pos = zp + 4;
    @(negedge clk);
    load = 1'b0;
    repeat (10) @(negedge clk);
    check(done, 0, done === 1'b0);
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(done, 1, done === 1'b1);
    if (done !== 1'b1) tally_and_finish();
    spd_zero = 1'b0;
    repeat (3) @(negedge clk);
    check(done, 0, done === 1'b0);
    spd_zero = 1'b1;
  endtask

  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    method_7();
    bad_method();
    method_8();
    method_9();
    method_10();
    method_11();
    done_window();
    tally_and_finish();
  end
endmodule
